/* hdl/sbt_pkg.sv */
package sbt_pkg;

  localparam int NUM_BANKS = 4;
  localparam int BANK_W = 2;
  localparam int ADDR_W = 12;
  localparam int MODE_W = ADDR_W + BANK_W;
  localparam int PRECHARGE_SELECT_BIT = 10;
  localparam int BL_LSB = 0;
  localparam int BL_MSB = 2;
  localparam int CNT_W = 10;

  localparam logic [MODE_W-1:0] MODE_RESET = 14'h0000;

  localparam logic [2:0] BL_CODE_1 = 3'h0;
  localparam logic [2:0] BL_CODE_2 = 3'h1;
  localparam logic [2:0] BL_CODE_4 = 3'h2;
  localparam logic [2:0] BL_CODE_8 = 3'h3;
  localparam logic [2:0] BL_CODE_PAGE = 3'h7;
  localparam logic [CNT_W-1:0] BURST_1 = 10'h001;
  localparam logic [CNT_W-1:0] BURST_2 = 10'h002;
  localparam logic [CNT_W-1:0] BURST_4 = 10'h004;
  localparam logic [CNT_W-1:0] BURST_8 = 10'h008;
  localparam logic [CNT_W-1:0] FULL_PAGE_LEN = 10'h100;

  // times in ns; cycle counts derived at the 50 MHz clock
  localparam int CLK_PERIOD_NS = 20;
  localparam int ROW_PRECHARGE_TIME_NS = 20;
  localparam int ROW_TO_COLUMN_TIME_NS = 20;
  localparam int ROW_CYCLE_TIME_NS = 70;
  localparam int WRITE_RECOVERY_TIME_NS = 15;
  localparam int MODE_SET_CYCLE_CLKS = 2;

  function automatic logic [CNT_W-1:0] ns_to_cycles(input int t_ns);
    int c;
    c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    if (c < 1) begin
      c = 1;
    end
    return c[CNT_W-1:0];
  endfunction

  localparam logic [CNT_W-1:0] ROW_PRECHARGE_CYCLES = ns_to_cycles(ROW_PRECHARGE_TIME_NS);
  localparam logic [CNT_W-1:0] ROW_TO_COLUMN_CYCLES = ns_to_cycles(ROW_TO_COLUMN_TIME_NS);
  localparam logic [CNT_W-1:0] ROW_CYCLE_CYCLES = ns_to_cycles(ROW_CYCLE_TIME_NS);
  localparam logic [CNT_W-1:0] WRITE_RECOVERY_CYCLES = ns_to_cycles(WRITE_RECOVERY_TIME_NS);
  localparam logic [CNT_W-1:0] MODE_SET_CYCLES = MODE_SET_CYCLE_CLKS[CNT_W-1:0];

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ACTIVATING,
    ST_ROW_ACTIVE,
    ST_READ,
    ST_READ_AUTO,
    ST_WRITE,
    ST_WRITE_AUTO,
    ST_WR_RECOVER,
    ST_WR_RECOVER_AUTO,
    ST_PRECHARGING,
    ST_REFRESHING,
    ST_MODE_ACCESS
  } sbt_state_t;

  typedef enum logic [3:0] {
    CMD_DESELECT,
    CMD_NOP,
    CMD_BURST_STOP,
    CMD_READ,
    CMD_WRITE,
    CMD_ACTIVATE,
    CMD_PRECHARGE,
    CMD_REFRESH,
    CMD_MODE_SET
  } sbt_cmd_t;

  function automatic sbt_cmd_t sbt_decode(input logic cs_n, input logic ras_n,
                                          input logic cas_n, input logic we_n);
    sbt_cmd_t c;
    c = CMD_DESELECT;
    if (!cs_n) begin
      case ({ras_n, cas_n, we_n})
        3'h7: c = CMD_NOP;
        3'h6: c = CMD_BURST_STOP;
        3'h5: c = CMD_READ;
        3'h4: c = CMD_WRITE;
        3'h3: c = CMD_ACTIVATE;
        3'h2: c = CMD_PRECHARGE;
        3'h1: c = CMD_REFRESH;
        default: c = CMD_MODE_SET;
      endcase
    end
    return c;
  endfunction

endpackage

/* hdl/sbt_timer.sv */
`timescale 1ns/1ps
module sbt_timer (
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [sbt_pkg::CNT_W-1:0] load_val,
  input wire logic run,
  output logic last
);
  import sbt_pkg::*;

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  localparam logic [CNT_W-1:0] ONE = 10'h001;
  localparam logic [CNT_W-1:0] ZERO = 10'h000;

  // frozen while run is low, so a suspended clock stretches the state
  assign cnt_nxt = load ? load_val : ((run && cnt_r != ZERO) ? cnt_r - ONE : cnt_r);
  assign last = run && (cnt_r == ONE);

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= ZERO;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule

/* hdl/sbt_bank_ctrl.sv */
`timescale 1ns/1ps
// Overview of operation
// - read auto-precharge: idle commands finish, then precharge
// - write auto-precharge: finish burst, recover, then precharge
// - precharging ignores idle/precharge commands, idle after row_precharge_time
// - activating ignores idle commands, active after delay
// - write recovery ignores idle/stop, active after write_recovery_time
// - write recovery accepts read, option from command
// - write recovery accepts write, option from command
// - recovery with precharge ignores idle/stop, then precharges
// - refresh takes only idle/stop, idle after row_cycle_time
// - mode set takes idle commands, idle after mode_set_cycle_time
// - precharge_select_bit high selects auto precharge
// - commands act only if clock enable was high
module sbt_bank_ctrl (
  input wire logic clk,
  input wire logic rst,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [sbt_pkg::BANK_W-1:0] ba,
  input wire logic [sbt_pkg::ADDR_W-1:0] addr,
  output sbt_pkg::sbt_state_t bank_state [sbt_pkg::NUM_BANKS],
  output logic [sbt_pkg::MODE_W-1:0] mode_reg,
  output logic illegal_cmd
);
  import sbt_pkg::*;

  logic cke_prev_r;
  logic illegal_r;
  logic illegal_nxt;
  logic [MODE_W-1:0] mode_r;
  logic [MODE_W-1:0] mode_nxt;
  sbt_state_t state_r [NUM_BANKS];
  sbt_state_t state_nxt [NUM_BANKS];
  logic [NUM_BANKS-1:0] hit;
  logic [NUM_BANKS-1:0] bad;
  logic [NUM_BANKS-1:0] tmr_load;
  logic [NUM_BANKS-1:0] tmr_last;
  logic [CNT_W-1:0] tmr_val [NUM_BANKS];
  logic [NUM_BANKS-1:0] bank_idle;

  wire cmd_live = cke_prev_r;
  wire sbt_cmd_t cmd = sbt_decode(cs_n, ras_n, cas_n, we_n);
  wire auto_sel = addr[PRECHARGE_SELECT_BIT];
  wire all_idle = &bank_idle;
  wire mode_take = cmd_live && cmd == CMD_MODE_SET && all_idle;
  wire [CNT_W-1:0] burst_len = bl_cycles(mode_r[BL_MSB:BL_LSB]);

  function automatic logic [CNT_W-1:0] bl_cycles(input logic [2:0] code);
    logic [CNT_W-1:0] n;
    case (code)
      BL_CODE_1: n = BURST_1;
      BL_CODE_2: n = BURST_2;
      BL_CODE_4: n = BURST_4;
      BL_CODE_8: n = BURST_8;
      BL_CODE_PAGE: n = FULL_PAGE_LEN;
      default: n = BURST_1;
    endcase
    return n;
  endfunction

  // whether a command aimed at this bank is allowed in its state
  function automatic logic cmd_legal(input sbt_state_t st, input sbt_cmd_t c);
    logic ok;
    ok = 1'b0;
    case (c)
      CMD_DESELECT, CMD_NOP: ok = 1'b1;
      CMD_BURST_STOP: ok = st inside {ST_IDLE, ST_ROW_ACTIVE, ST_READ, ST_WRITE,
                                      ST_WR_RECOVER, ST_WR_RECOVER_AUTO,
                                      ST_REFRESHING};
      CMD_READ, CMD_WRITE: ok = st inside {ST_ROW_ACTIVE, ST_READ, ST_WRITE,
                                           ST_WR_RECOVER};
      CMD_ACTIVATE: ok = (st == ST_IDLE);
      CMD_PRECHARGE: ok = st inside {ST_IDLE, ST_ROW_ACTIVE, ST_READ, ST_WRITE,
                                     ST_PRECHARGING};
      CMD_REFRESH, CMD_MODE_SET: ok = (st == ST_IDLE);
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // state reached when the timer of a timed state runs out
  function automatic sbt_state_t timeout_state(input sbt_state_t st);
    sbt_state_t n;
    case (st)
      ST_READ_AUTO: n = ST_PRECHARGING;
      ST_WRITE_AUTO: n = ST_WR_RECOVER_AUTO;
      ST_READ: n = ST_ROW_ACTIVE;
      ST_WRITE: n = ST_WR_RECOVER;
      ST_WR_RECOVER: n = ST_ROW_ACTIVE;
      ST_WR_RECOVER_AUTO: n = ST_PRECHARGING;
      ST_PRECHARGING: n = ST_IDLE;
      ST_ACTIVATING: n = ST_ROW_ACTIVE;
      ST_REFRESHING: n = ST_IDLE;
      ST_MODE_ACCESS: n = ST_IDLE;
      default: n = st;
    endcase
    return n;
  endfunction

  // response to a legal command that reaches this bank
  function automatic sbt_state_t cmd_state(input sbt_state_t st, input sbt_cmd_t c,
                                           input logic auto_pre);
    sbt_state_t n;
    n = st;
    case (c)
      CMD_READ: n = auto_pre ? ST_READ_AUTO : ST_READ;
      CMD_WRITE: n = auto_pre ? ST_WRITE_AUTO : ST_WRITE;
      CMD_ACTIVATE: n = ST_ACTIVATING;
      CMD_REFRESH: n = ST_REFRESHING;
      CMD_MODE_SET: n = ST_MODE_ACCESS;
      CMD_PRECHARGE: n = (st == ST_IDLE || st == ST_PRECHARGING) ? st : ST_PRECHARGING;
      CMD_BURST_STOP: n = (st == ST_READ || st == ST_WRITE) ? ST_ROW_ACTIVE : st;
      default: n = st;
    endcase
    return n;
  endfunction

  // cycles spent in a state from the edge that enters it
  function automatic logic [CNT_W-1:0] entry_count(input sbt_state_t st,
                                                   input logic [CNT_W-1:0] bl);
    logic [CNT_W-1:0] n;
    case (st)
      ST_READ, ST_READ_AUTO, ST_WRITE, ST_WRITE_AUTO: n = bl;
      ST_WR_RECOVER, ST_WR_RECOVER_AUTO: n = WRITE_RECOVERY_CYCLES;
      ST_PRECHARGING: n = ROW_PRECHARGE_CYCLES;
      ST_ACTIVATING: n = ROW_TO_COLUMN_CYCLES;
      ST_REFRESHING: n = ROW_CYCLE_CYCLES;
      ST_MODE_ACCESS: n = MODE_SET_CYCLES;
      default: n = '0;
    endcase
    return n;
  endfunction

  genvar b;
  generate
    for (b = 0; b < NUM_BANKS; b++) begin : g_bank
      wire own_bank = (ba == BANK_W'(b));
      wire device_wide = state_r[b] inside {ST_REFRESHING, ST_MODE_ACCESS};
      wire column = (cmd == CMD_READ || cmd == CMD_WRITE);
      wire legal = cmd_legal(state_r[b], cmd);
      wire taken = cmd_live && hit[b] && legal;
      wire sbt_state_t by_cmd = cmd_state(state_r[b], cmd, auto_sel);
      wire restart = taken && column;

      // refresh, mode set and burst stop reach every bank
      always_comb begin
        case (cmd)
          CMD_READ, CMD_WRITE, CMD_ACTIVATE: hit[b] = own_bank || device_wide;
          CMD_PRECHARGE: hit[b] = own_bank || auto_sel || device_wide;
          CMD_DESELECT, CMD_NOP: hit[b] = 1'b0;
          default: hit[b] = 1'b1;
        endcase
      end

      assign bad[b] = cmd_live && hit[b] && !legal;
      assign bank_idle[b] = (state_r[b] == ST_IDLE);

      // a new column command wins over the end of the burst or recovery
      always_comb begin
        state_nxt[b] = state_r[b];
        if ((cmd == CMD_REFRESH || cmd == CMD_MODE_SET) && taken && !all_idle) begin
          state_nxt[b] = state_r[b];
        end else if (taken && by_cmd != state_r[b]) begin
          state_nxt[b] = by_cmd;
        end else if (!restart && tmr_last[b]) begin
          state_nxt[b] = timeout_state(state_r[b]);
        end
      end

      assign tmr_load[b] = restart || (state_nxt[b] != state_r[b]);
      assign tmr_val[b] = entry_count(state_nxt[b], burst_len);

      sbt_timer u_timer (
        .clk(clk),
        .rst(rst),
        .load(tmr_load[b]),
        .load_val(tmr_val[b]),
        .run(cmd_live),
        .last(tmr_last[b])
      );

      always_ff @(posedge clk) begin
        if (rst) begin
          state_r[b] <= ST_IDLE;
        end else begin
          state_r[b] <= state_nxt[b];
        end
      end

      assign bank_state[b] = state_r[b];
    end
  endgenerate

  // refresh or mode set with any bank busy is refused for all banks
  wire wide_refused = cmd_live && (cmd == CMD_REFRESH || cmd == CMD_MODE_SET) && !all_idle;

  assign illegal_nxt = (|bad) || wide_refused;
  assign mode_nxt = mode_take ? {ba, addr} : mode_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      cke_prev_r <= 1'b0;
      illegal_r <= 1'b0;
      mode_r <= MODE_RESET;
    end else begin
      cke_prev_r <= cke;
      illegal_r <= illegal_nxt;
      mode_r <= mode_nxt;
    end
  end

  assign mode_reg = mode_r;
  assign illegal_cmd = illegal_r;
endmodule

/* verification/sbt_bank_monitor.sv */
`timescale 1ns/1ps
module sbt_bank_monitor (
  input logic clk,
  input logic rst,
  input logic cke,
  input logic cs_n,
  input logic ras_n,
  input logic cas_n,
  input logic we_n,
  input logic [sbt_pkg::BANK_W-1:0] ba,
  input logic [sbt_pkg::ADDR_W-1:0] addr,
  input sbt_pkg::sbt_state_t bank_state [sbt_pkg::NUM_BANKS],
  input logic illegal_cmd
);
  import sbt_pkg::*;
  logic cke_en_r;
  sbt_state_t s0;
  wire idle_c = cs_n | (ras_n & cas_n & we_n);
  wire stop_c = !cs_n & ras_n & cas_n & !we_n;
  wire col_c = !cs_n & ras_n & !cas_n;
  wire refresh_c = !cs_n & !ras_n & !cas_n & we_n;
  wire auto_c = addr[PRECHARGE_SELECT_BIT];
  assign s0 = bank_state[0];
  // an edge only counts when cke was high one edge earlier
  always_ff @(posedge clk) begin
    cke_en_r <= rst ? 1'b0 : cke;
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  property p_prech;
    (s0 == ST_PRECHARGING && cke_en_r && idle_c) |=> s0 == ST_IDLE;
  endproperty
  a_prech: assert property (p_prech) else $error("precharge exit");
  property p_actv;
    (s0 == ST_ACTIVATING && cke_en_r && idle_c) |=> s0 == ST_ROW_ACTIVE;
  endproperty
  a_actv: assert property (p_actv) else $error("activate exit");
  property p_wrrec;
    (s0 == ST_WR_RECOVER && cke_en_r && (idle_c || stop_c)) |=> s0 == ST_ROW_ACTIVE;
  endproperty
  a_wrrec: assert property (p_wrrec) else $error("recovery exit");
  property p_wrcol;
    (s0 == ST_WR_RECOVER && cke_en_r && col_c && ba == 2'h0) |=> s0 == ($past(we_n) ?
      ($past(auto_c) ? ST_READ_AUTO : ST_READ) : ($past(auto_c) ? ST_WRITE_AUTO : ST_WRITE));
  endproperty
  a_wrcol: assert property (p_wrcol) else $error("column in recovery");
  property p_wrrap;
    (s0 == ST_WR_RECOVER_AUTO && cke_en_r && (idle_c || stop_c)) |=> s0 == ST_PRECHARGING;
  endproperty
  a_wrrap: assert property (p_wrrap) else $error("recovery ap exit");
  property p_refr;
    $rose(s0 == ST_REFRESHING) ##0 cke_en_r [*4] |=> s0 == ST_IDLE;
  endproperty
  a_refr: assert property (p_refr) else $error("refresh length");
  property p_mode;
    $rose(s0 == ST_MODE_ACCESS) ##0 cke_en_r [*2] |=> s0 == ST_IDLE;
  endproperty
  a_mode: assert property (p_mode) else $error("mode set length");
  property p_bstill;
    (stop_c && cke_en_r && s0 inside {ST_READ_AUTO, ST_WRITE_AUTO, ST_PRECHARGING,
      ST_ACTIVATING, ST_MODE_ACCESS}) |=> illegal_cmd;
  endproperty
  a_bstill: assert property (p_bstill) else $error("stop not flagged");
  property p_frozen;
    !cke_en_r |=> $stable(s0) && !illegal_cmd;
  endproperty
  a_frozen: assert property (p_frozen) else $error("state moved while suspended");
  property p_wide;
    (refresh_c && cke_en_r && s0 != ST_IDLE) |=> illegal_cmd;
  endproperty
  a_wide: assert property (p_wide) else $error("busy refresh not refused");
endmodule

bind sbt_bank_ctrl sbt_bank_monitor mon (
  .clk(clk), .rst(rst), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
  .we_n(we_n), .ba(ba), .addr(addr), .bank_state(bank_state), .illegal_cmd(illegal_cmd)
);

/* verification/sbt_cmd_model.sv */
`timescale 1ns/1ps
module sbt_cmd_model (
  input wire logic clk,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [sbt_pkg::BANK_W-1:0] ba,
  output logic [sbt_pkg::ADDR_W-1:0] addr
);
  import sbt_pkg::*;
  initial begin
    {cs_n, ras_n, cas_n, we_n, ba, addr} = {4'hF, 2'h0, 12'h000};
  end
  // pins change after the falling edge and hold across one rising edge
  task automatic send(input sbt_cmd_t c, input logic [BANK_W-1:0] b,
                      input logic [ADDR_W-1:0] a);
    @(negedge clk);
    if (c == CMD_DESELECT) begin
      // released lines flip so a stale command never looks valid
      {cs_n, ras_n, cas_n, we_n} = {1'b1, ~ras_n, ~cas_n, ~we_n};
      addr = ~addr;
    end else begin
      // command enum order runs opposite to the pin code
      {cs_n, ras_n, cas_n, we_n} = {1'b0, 3'(4'h8 - 4'(c))};
      ba = b;
      addr = a;
    end
    @(posedge clk);
    #1;
  endtask
endmodule

/* verification/sdram_bank_transient_states_tb.sv */
`timescale 1ns/1ps
module sdram_bank_transient_states_tb;
  import sbt_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cke = 1'b1;
  logic cs_n, ras_n, cas_n, we_n, illegal_cmd;
  logic [BANK_W-1:0] ba;
  logic [ADDR_W-1:0] addr;
  logic [MODE_W-1:0] mode_reg;
  sbt_state_t bank_state [NUM_BANKS];
  int err_total = 0;
  int compares = 0;
  always #10 clk = ~clk;
  sbt_cmd_model ctl (.clk(clk), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .ba(ba), .addr(addr));
  sbt_bank_ctrl dut (.clk(clk), .rst(rst), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .bank_state(bank_state),
    .mode_reg(mode_reg), .illegal_cmd(illegal_cmd));
  task automatic give_verdict();
    if (err_total == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic step(input sbt_cmd_t c, input logic [ADDR_W-1:0] a, input sbt_state_t exp);
    ctl.send(c, 2'h0, a);
    chk(16'(bank_state[0]), 16'(exp));
  endtask
  // bounded wait; used after an illegal burst stop and to wait out a read with auto precharge
  task automatic settle(input sbt_state_t exp);
    int n;
    n = 0;
    while (bank_state[0] !== exp && n < 20) begin
      ctl.send(CMD_DESELECT, 2'h0, 12'h000);
      n++;
    end
    if (bank_state[0] !== exp) begin
      chk(16'(bank_state[0]), 16'(exp));
      give_verdict();
    end
  endtask
  task automatic open_row();
    step(CMD_ACTIVATE, 12'h000, ST_ACTIVATING);
    step(CMD_NOP, 12'h000, ST_ROW_ACTIVE);
  endtask
  task automatic t_mode();
    step(CMD_MODE_SET, {9'h000, BL_CODE_4}, ST_MODE_ACCESS);
    chk(16'(mode_reg), 16'({2'h0, 9'h000, BL_CODE_4}));
    step(CMD_DESELECT, 12'h000, ST_MODE_ACCESS);
    step(CMD_NOP, 12'h000, ST_IDLE);
  endtask
  task automatic t_read_ap();
    open_row();
    step(CMD_READ, 12'h400, ST_READ_AUTO);
    repeat (3) step(CMD_NOP, 12'h000, ST_READ_AUTO);
    step(CMD_DESELECT, 12'h000, ST_PRECHARGING);
    step(CMD_PRECHARGE, 12'h400, ST_IDLE);
  endtask
  task automatic t_write_ap();
    open_row();
    step(CMD_WRITE, 12'h400, ST_WRITE_AUTO);
    step(CMD_BURST_STOP, 12'h000, ST_WRITE_AUTO);
    chk(16'(illegal_cmd), 16'h0001);
    settle(ST_WR_RECOVER_AUTO);
    step(CMD_BURST_STOP, 12'h000, ST_PRECHARGING);
    step(CMD_DESELECT, 12'h000, ST_IDLE);
  endtask
  task automatic to_recover();
    repeat (3) step(CMD_NOP, 12'h000, ST_WRITE);
    step(CMD_NOP, 12'h000, ST_WR_RECOVER);
  endtask
  task automatic t_wr_recover();
    open_row();
    step(CMD_WRITE, 12'h000, ST_WRITE);
    to_recover();
    step(CMD_BURST_STOP, 12'h000, ST_ROW_ACTIVE);
    step(CMD_WRITE, 12'h000, ST_WRITE);
    to_recover();
    step(CMD_WRITE, 12'h000, ST_WRITE);
    to_recover();
    step(CMD_READ, 12'h400, ST_READ_AUTO);
    settle(ST_IDLE);
  endtask
  task automatic t_refresh();
    step(CMD_REFRESH, 12'h000, ST_REFRESHING);
    step(CMD_BURST_STOP, 12'h000, ST_REFRESHING);
    chk(16'(illegal_cmd), 16'h0000);
    repeat (2) step(CMD_NOP, 12'h000, ST_REFRESHING);
    step(CMD_DESELECT, 12'h000, ST_IDLE);
  endtask
  // cke low freezes the refresh count, so idle comes late
  task automatic t_suspend();
    step(CMD_REFRESH, 12'h000, ST_REFRESHING);
    @(negedge clk);
    cke = 1'b0;
    step(CMD_NOP, 12'h000, ST_REFRESHING);
    step(CMD_ACTIVATE, 12'h000, ST_REFRESHING);
    chk(16'(illegal_cmd), 16'h0000);
    step(CMD_NOP, 12'h000, ST_REFRESHING);
    @(negedge clk);
    cke = 1'b1;
    repeat (2) step(CMD_NOP, 12'h000, ST_REFRESHING);
    step(CMD_NOP, 12'h000, ST_IDLE);
  endtask
  task automatic t_refused();
    open_row();
    step(CMD_REFRESH, 12'h000, ST_ROW_ACTIVE);
    chk(16'(illegal_cmd), 16'h0001);
    chk(16'(bank_state[1]), 16'(ST_IDLE));
    step(CMD_PRECHARGE, 12'h400, ST_PRECHARGING);
    chk(16'(illegal_cmd), 16'h0000);
    chk(16'(bank_state[1]), 16'(ST_IDLE));
    step(CMD_NOP, 12'h000, ST_IDLE);
  endtask
  task automatic t_burst2();
    step(CMD_MODE_SET, {9'h000, BL_CODE_2}, ST_MODE_ACCESS);
    chk(16'(mode_reg), 16'({2'h0, 9'h000, BL_CODE_2}));
    step(CMD_DESELECT, 12'h000, ST_MODE_ACCESS);
    step(CMD_NOP, 12'h000, ST_IDLE);
    open_row();
    step(CMD_READ, 12'h400, ST_READ_AUTO);
    step(CMD_NOP, 12'h000, ST_READ_AUTO);
    step(CMD_NOP, 12'h000, ST_PRECHARGING);
    step(CMD_DESELECT, 12'h000, ST_IDLE);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    ctl.send(CMD_DESELECT, 2'h0, 12'h000);
    t_mode();
    t_read_ap();
    t_write_ap();
    t_wr_recover();
    t_refresh();
    t_suspend();
    t_refused();
    t_burst2();
    give_verdict();
  end
endmodule
